// ===== sralis_pkg.sv
package sralis_pkg;
  // register offsets
  localparam logic [7:0] PROX_RESULT_ALIGNMENT_OFS = 8'h05;
  localparam logic [7:0] AMBIENT_RESULT_ALIGNMENT_OFS = 8'h06;
  localparam logic [7:0] PROX1_INPUT_SELECT_OFS = 8'h07;
  localparam logic [7:0] PROX2_INPUT_SELECT_OFS = 8'h08;
  localparam logic [7:0] PROX3_INPUT_SELECT_OFS = 8'h09;
  localparam logic [7:0] PROX_CONVERTER_MISC_OFS = 8'h0c;
  localparam logic [7:0] SEQ_STATUS_OFS = 8'h0d;

  // field positions
  localparam int PROX1_LOW_BITS_POS = 4;
  localparam int PROX2_LOW_BITS_POS = 5;
  localparam int PROX3_LOW_BITS_POS = 6;
  localparam int AMBIENT_INFRARED_LOW_BITS_POS = 5;
  localparam int AMBIENT_VISIBLE_LOW_BITS_POS = 4;
  localparam int PROX_CONVERTER_MODE_POS = 2;

  // writable bit masks
  localparam logic [7:0] PROX_ALIGN_WMASK = 8'h70;
  localparam logic [7:0] AMBIENT_ALIGN_WMASK = 8'h30;
  localparam logic [7:0] PROX_MISC_WMASK = 8'h04;

  // reset values
  localparam logic [7:0] PROX_ALIGN_RST = 8'h00;
  localparam logic [7:0] AMBIENT_ALIGN_RST = 8'h00;
  localparam logic [7:0] PROX_SELECT_RST = 8'h03;
  localparam logic [7:0] PROX_MISC_RST = 8'h04;

  // converter input select codes
  localparam logic [7:0] SEL_LARGE_IR = 8'h03;
  localparam logic [7:0] SEL_SMALL_IR = 8'h00;
  localparam logic [7:0] SEL_VISIBLE = 8'h02;
  localparam logic [7:0] SEL_NO_DIODE = 8'h06;
  localparam logic [7:0] SEL_GROUND = 8'h25;
  localparam logic [7:0] SEL_TEMPERATURE = 8'h65;
  localparam logic [7:0] SEL_SUPPLY = 8'h75;

  // measurement channels
  localparam logic [2:0] CHAN_PROX1 = 3'h0;
  localparam logic [2:0] CHAN_PROX2 = 3'h1;
  localparam logic [2:0] CHAN_PROX3 = 3'h2;
  localparam logic [2:0] CHAN_AMB_VIS = 3'h3;
  localparam logic [2:0] CHAN_AMB_IR = 3'h4;
endpackage : sralis_pkg

// ===== sralis_top.sv
`timescale 1ns/100ps
module sralis_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_meas_start,
  input wire logic [2:0] i_meas_chan,
  input wire logic [2:0] i_led_request,
  input wire logic i_conv_valid,
  input wire logic [2:0] i_conv_chan,
  input wire logic [16:0] i_conv_result,
  output logic [7:0] o_adc_input_sel,
  output logic o_adc_sel_legal,
  output logic [2:0] o_led_drive,
  output logic o_raw_mode,
  output logic o_result_valid,
  output logic [2:0] o_result_chan,
  output logic [15:0] o_result_data
);

  logic [7:0] prox_result_alignment_r;
  logic [7:0] ambient_result_alignment_r;
  logic [7:0] prox1_input_select_r;
  logic [7:0] prox2_input_select_r;
  logic [7:0] prox3_input_select_r;
  logic [7:0] prox_converter_misc_r;
  logic [2:0] last_chan_r;
  logic last_legal_r;
  logic [7:0] rdata_nxt;
  logic prox_converter_mode;
  logic [7:0] sel_nxt;
  logic low_bits_nxt;

  // input select code check against current mode
  function automatic logic sel_is_legal(input logic [7:0] sel, input logic normal);
    logic ok;
    ok = 1'b0;
    if (sel == sralis_pkg::SEL_LARGE_IR || sel == sralis_pkg::SEL_SMALL_IR) begin
      ok = 1'b1;
    end else if (!normal) begin
      ok = (sel == sralis_pkg::SEL_VISIBLE) ||
           (sel == sralis_pkg::SEL_NO_DIODE) ||
           (sel == sralis_pkg::SEL_GROUND) ||
           (sel == sralis_pkg::SEL_TEMPERATURE) ||
           (sel == sralis_pkg::SEL_SUPPLY);
    end
    return ok;
  endfunction : sel_is_legal

  // picks 16 of the 17 converter bits
  function automatic logic [15:0] align16(input logic [16:0] res, input logic low);
    return low ? res[15:0] : res[16:1];
  endfunction : align16

  assign prox_converter_mode = prox_converter_misc_r[sralis_pkg::PROX_CONVERTER_MODE_POS];

  // alignment registers, reserved bits masked
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prox_result_alignment_r <= sralis_pkg::PROX_ALIGN_RST;
      ambient_result_alignment_r <= sralis_pkg::AMBIENT_ALIGN_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == sralis_pkg::PROX_RESULT_ALIGNMENT_OFS) begin
        prox_result_alignment_r <= i_reg_wdata & sralis_pkg::PROX_ALIGN_WMASK;
      end
      if (i_reg_addr == sralis_pkg::AMBIENT_RESULT_ALIGNMENT_OFS) begin
        ambient_result_alignment_r <= i_reg_wdata & sralis_pkg::AMBIENT_ALIGN_WMASK;
      end
    end
  end

  // input select registers, all eight bits stored
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prox1_input_select_r <= sralis_pkg::PROX_SELECT_RST;
      prox2_input_select_r <= sralis_pkg::PROX_SELECT_RST;
      prox3_input_select_r <= sralis_pkg::PROX_SELECT_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == sralis_pkg::PROX1_INPUT_SELECT_OFS) begin
        prox1_input_select_r <= i_reg_wdata;
      end
      if (i_reg_addr == sralis_pkg::PROX2_INPUT_SELECT_OFS) begin
        prox2_input_select_r <= i_reg_wdata;
      end
      if (i_reg_addr == sralis_pkg::PROX3_INPUT_SELECT_OFS) begin
        prox3_input_select_r <= i_reg_wdata;
      end
    end
  end

  // converter mode register, only the mode bit kept
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prox_converter_misc_r <= sralis_pkg::PROX_MISC_RST;
    end else if (i_reg_wr && i_reg_addr == sralis_pkg::PROX_CONVERTER_MISC_OFS) begin
      prox_converter_misc_r <= i_reg_wdata & sralis_pkg::PROX_MISC_WMASK;
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (i_reg_addr)
      sralis_pkg::PROX_RESULT_ALIGNMENT_OFS: rdata_nxt = prox_result_alignment_r;
      sralis_pkg::AMBIENT_RESULT_ALIGNMENT_OFS: rdata_nxt = ambient_result_alignment_r;
      sralis_pkg::PROX1_INPUT_SELECT_OFS: rdata_nxt = prox1_input_select_r;
      sralis_pkg::PROX2_INPUT_SELECT_OFS: rdata_nxt = prox2_input_select_r;
      sralis_pkg::PROX3_INPUT_SELECT_OFS: rdata_nxt = prox3_input_select_r;
      sralis_pkg::PROX_CONVERTER_MISC_OFS: rdata_nxt = prox_converter_misc_r;
      sralis_pkg::SEQ_STATUS_OFS: rdata_nxt = {4'h0, last_legal_r, last_chan_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_nxt;
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // select code per channel, shared encoding for all three
  always_comb begin
    sel_nxt = prox1_input_select_r;
    unique case (i_meas_chan)
      sralis_pkg::CHAN_PROX2: sel_nxt = prox2_input_select_r;
      sralis_pkg::CHAN_PROX3: sel_nxt = prox3_input_select_r;
      default: sel_nxt = prox1_input_select_r;
    endcase
  end

  // converter input routing at measurement start
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_adc_input_sel <= sralis_pkg::PROX_SELECT_RST;
      o_adc_sel_legal <= 1'b1;
      last_chan_r <= 3'h0;
      last_legal_r <= 1'b1;
    end else if (i_meas_start && i_meas_chan <= sralis_pkg::CHAN_PROX3) begin
      o_adc_input_sel <= sel_nxt;
      o_adc_sel_legal <= sel_is_legal(sel_nxt, prox_converter_mode);
      last_chan_r <= i_meas_chan;
      last_legal_r <= sel_is_legal(sel_nxt, prox_converter_mode);
    end
  end

  // led drive gated off in raw mode
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_led_drive <= 3'h0;
      o_raw_mode <= 1'b0;
    end else begin
      o_led_drive <= prox_converter_mode ? i_led_request : 3'h0;
      o_raw_mode <= !prox_converter_mode;
    end
  end

  // alignment bit for the finished channel
  always_comb begin
    low_bits_nxt = 1'b0;
    unique case (i_conv_chan)
      sralis_pkg::CHAN_PROX1: low_bits_nxt =
        prox_result_alignment_r[sralis_pkg::PROX1_LOW_BITS_POS];
      sralis_pkg::CHAN_PROX2: low_bits_nxt =
        prox_result_alignment_r[sralis_pkg::PROX2_LOW_BITS_POS];
      sralis_pkg::CHAN_PROX3: low_bits_nxt =
        prox_result_alignment_r[sralis_pkg::PROX3_LOW_BITS_POS];
      sralis_pkg::CHAN_AMB_IR: low_bits_nxt =
        ambient_result_alignment_r[sralis_pkg::AMBIENT_INFRARED_LOW_BITS_POS];
      sralis_pkg::CHAN_AMB_VIS: low_bits_nxt =
        ambient_result_alignment_r[sralis_pkg::AMBIENT_VISIBLE_LOW_BITS_POS];
      default: low_bits_nxt = 1'b0;
    endcase
  end

  // reported 16-bit result
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_result_valid <= 1'b0;
      o_result_chan <= 3'h0;
      o_result_data <= 16'h0000;
    end else begin
      o_result_valid <= i_conv_valid && i_conv_chan <= sralis_pkg::CHAN_AMB_IR;
      if (i_conv_valid) begin
        o_result_chan <= i_conv_chan;
        o_result_data <= align16(i_conv_result, low_bits_nxt);
      end
    end
  end

endmodule : sralis_top

// ===== sralis_properties.sv
`timescale 1ns/100ps
module sralis_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_conv_valid,
  input wire logic [2:0] i_conv_chan,
  input wire logic [16:0] i_conv_result,
  input wire logic [7:0] o_adc_input_sel,
  input wire logic o_adc_sel_legal,
  input wire logic [2:0] o_led_drive,
  input wire logic o_raw_mode,
  input wire logic o_result_valid,
  input wire logic [15:0] o_result_data
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);
  a_read_idle_zero: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("read data not idle");
  a_prox_reserved_zero: assert property (i_reg_rd && i_reg_addr == 8'h05 |=>
    o_reg_rdata[3:0] == 4'h0 && !o_reg_rdata[7]) else $error("prox align reserved set");
  a_amb_reserved_zero: assert property (i_reg_rd && i_reg_addr == 8'h06 |=>
    (o_reg_rdata & 8'hcf) == 8'h00) else $error("ambient reserved set");
  a_unmapped_zero: assert property (i_reg_rd && !(i_reg_addr inside
    {[8'h05:8'h09], 8'h0c, 8'h0d}) |=> o_reg_rdata == 8'h00) else $error("unmapped read");
  a_result_pulse: assert property (i_conv_valid && i_conv_chan < 3'h5 |=> o_result_valid)
    else $error("result valid missing");
  a_result_refused: assert property (!i_conv_valid || i_conv_chan > 3'h4 |=> !o_result_valid)
    else $error("result valid unexpected");
  a_result_slice: assert property (i_conv_valid |=>
    {1'b0, o_result_data} == ($past(i_conv_result) & 17'h0ffff) ||
    {o_result_data, 1'b0} == ($past(i_conv_result) & 17'h1fffe)) else $error("bad slice");
  a_raw_led_off: assert property (o_raw_mode |-> o_led_drive == 3'h0)
    else $error("led drive in raw mode");
  a_legal_code_set: assert property (o_adc_sel_legal |-> o_adc_input_sel inside
    {8'h00, 8'h02, 8'h03, 8'h06, 8'h25, 8'h65, 8'h75}) else $error("bad legal code");
  a_diode_always_legal: assert property (o_adc_input_sel inside {8'h00, 8'h03} |->
    o_adc_sel_legal) else $error("diode select not legal");
  cover property (i_conv_valid ##1 o_result_valid);
  cover property (o_raw_mode && o_adc_sel_legal);
  cover property (i_reg_rd ##1 o_reg_rdata != 8'h00);
endmodule : sralis_checker
bind sralis_top sralis_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
  .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_conv_valid(i_conv_valid), .i_conv_chan(i_conv_chan), .i_conv_result(i_conv_result),
  .o_adc_input_sel(o_adc_input_sel), .o_adc_sel_legal(o_adc_sel_legal),
  .o_led_drive(o_led_drive), .o_raw_mode(o_raw_mode), .o_result_valid(o_result_valid),
  .o_result_data(o_result_data));

// ===== sensor_result_align_input_select_tb.sv
`timescale 1ns/100ps
module sensor_result_align_input_select_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0, wr = 1'b0, rd = 1'b0, start = 1'b0, cv = 1'b0, leg, raw, rv;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat, sel;
  logic [2:0] mc = 3'h0, led = 3'h5, cc = 3'h0, ledo, rch;
  logic [16:0] cr = 17'h00000;
  logic [15:0] rdo;
  logic [7:0] codes [7] = '{8'h03, 8'h00, 8'h02, 8'h06, 8'h25, 8'h65, 8'h75};
  int miscompares = 0, check_count = 0, cycles = 0;
  always #2.5 clk = ~clk;
  sralis_top dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_meas_start(start),
    .i_meas_chan(mc), .i_led_request(led), .i_conv_valid(cv), .i_conv_chan(cc),
    .i_conv_result(cr), .o_adc_input_sel(sel), .o_adc_sel_legal(leg), .o_led_drive(ledo),
    .o_raw_mode(raw), .o_result_valid(rv), .o_result_chan(rch), .o_result_data(rdo));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdat}, {8'h00, e});
  endtask : rd_reg
  task automatic conv(input logic [2:0] c, input logic lo);
    @(posedge clk);
    cv <= 1'b1;
    cc <= c;
    cr <= 17'h12345;
    @(posedge clk);
    cv <= 1'b0;
    #1;
    chk({15'h0, rv}, {15'h0, c < 3'h5});
    if (c < 3'h5) chk(rdo, lo ? 16'h2345 : 16'h91a2);
    if (c < 3'h5) chk({13'h0, rch}, {13'h0, c});
  endtask : conv
  task automatic go(input logic [2:0] c, input logic [7:0] es, input logic el);
    @(posedge clk);
    start <= 1'b1;
    mc <= c;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk({8'h00, sel}, {8'h00, es});
    chk({15'h0, leg}, {15'h0, el});
  endtask : go
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(8'h05, 8'h00);
    rd_reg(8'h08, 8'h03);
    rd_reg(8'h09, 8'h03);
    rd_reg(8'h0c, 8'h04);
    rd_reg(8'h07, 8'h03);
    rd_reg(8'h06, 8'h00);
    rd_reg(8'h0d, 8'h08);
    wr_reg(8'h05, 8'hf0);
    rd_reg(8'h05, 8'h70);
    wr_reg(8'h06, 8'hff);
    rd_reg(8'h06, 8'h30);
    wr_reg(8'h20, 8'hff);
    rd_reg(8'h20, 8'h00);
    $display("register test done");
    for (int b = 0; b < 5; b++) begin
      wr_reg(8'h05, (b < 3) ? 8'h10 << b : 8'h00);
      wr_reg(8'h06, (b == 3) ? 8'h10 : (b == 4) ? 8'h20 : 8'h00);
      for (int c = 0; c < 6; c++) conv(3'(c), c == b);
    end
    $display("alignment test done");
    for (int m = 1; m >= 0; m--) begin
      wr_reg(8'h0c, m ? 8'h04 : 8'h00);
      for (int i = 0; i < 8; i++) begin
        wr_reg(8'h07 + 8'(i % 3), i < 7 ? codes[i] : 8'h01);
        go(3'(i % 3), i < 7 ? codes[i] : 8'h01, i < 2 || (m == 0 && i < 7));
      end
      chk({13'h0, ledo}, m ? {13'h0, led} : 16'h0);
      chk({15'h0, raw}, {15'h0, m == 0});
    end
    go(3'h3, 8'h01, 1'b0);
    rd_reg(8'h0d, 8'h01);
    $display("select test done");
    end_of_test;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      end_of_test;
    end
  end
endmodule : sensor_result_align_input_select_tb
